// [rsm_defines.vh]
`ifndef RSM_DEFINES_VH
`define RSM_DEFINES_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RSM_OFF_IRQ_STATUS 8'h02
`define RSM_OFF_MON_STAT0 8'h05
`define RSM_OFF_MON_STAT1 8'h06
`define RSM_OFF_IRQ_MASK 8'h09
`define RSM_OFF_MON_MASK0 8'h0C
`define RSM_OFF_MON_MASK1 8'h0D
`define RSM_OFF_SYNC_STAT0 8'h14
`define RSM_OFF_SYNC_STAT1 8'h15
`define RSM_OFF_OOR0 8'h16
`define RSM_OFF_OOR1 8'h17
`define RSM_OFF_ACC_MASK 8'h1A
`define RSM_OFF_LOOP_CTRL1 8'h1E
`define RSM_OFF_MODE 8'h1F
`define RSM_OFF_MAN_SEL 8'h20
`define RSM_OFF_REV_CTRL 8'h23
`define RSM_OFF_PRI0 8'h24
`define RSM_OFF_PRI1 8'h25
`define RSM_OFF_DECAY 8'h30
`define RSM_OFF_SEL_STAT 8'h31
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RSM_RST_IRQ_MASK 8'h00
`define RSM_RST_MON_MASK 8'h00
`define RSM_RST_OOR 8'h00
`define RSM_RST_ACC_MASK 8'h00
`define RSM_RST_LOOP_CTRL1 8'h00
`define RSM_RST_MODE 8'h01
`define RSM_RST_MAN_SEL 8'h00
`define RSM_RST_REV_CTRL 8'h00
`define RSM_RST_PRI0 8'h10
`define RSM_RST_PRI1 8'h02
`define RSM_RST_DECAY 8'h00
// ----------------------------------------------------------------
// field codes and positions
// ----------------------------------------------------------------
`define RSM_MODE_MANUAL 3'h0
`define RSM_MODE_AUTO 3'h1
`define RSM_REVERT_BIT 0
`define RSM_PRI_EXCLUDE 4'hF
`define RSM_ACC_CFM_LSB 4
// ----------------------------------------------------------------
// timing and thresholds
// ----------------------------------------------------------------
`define RSM_CLK_PERIOD_NS 5
`define RSM_CFM_WIN_US 30
`define RSM_CFM_WIN_CYC ((`RSM_CFM_WIN_US * 1000) / `RSM_CLK_PERIOD_NS)
`define RSM_PFM_WIN_S 10
`define RSM_PFM_WIN_CYC (`RSM_PFM_WIN_S * (32'd1000000000 / `RSM_CLK_PERIOD_NS))
`define RSM_GST_UPPER 8'h40
`define RSM_GST_LOWER 8'h08
`define RSM_GST_STEP 8'h08
`define RSM_DECAY_BASE 16'h00FF
`define RSM_NOM_PER 16'd25
`define RSM_SYNC_RATIO 16'd1000
`endif

// [rsm_ref_monitor.v]
`include "rsm_defines.vh"
`default_nettype none
module rsm_ref_monitor #(
  parameter [15:0] NOM_PER = `RSM_NOM_PER,
  parameter [31:0] CFM_WIN = `RSM_CFM_WIN_CYC,
  parameter [31:0] PFM_WIN = `RSM_PFM_WIN_CYC
) (
  input wire core_clk_in, // system clock
  input wire rst_n_in, // synchronous reset, active low
  input wire ref_in, // reference clock sample
  input wire mask_scm_acc_in, // keep period events out of accumulator
  input wire mask_cfm_acc_in, // keep coarse events out of accumulator
  input wire [1:0] decay_sel_in, // accumulator decay rate
  input wire [2:0] oor_code_in, // precise limit code
  output wire [3:0] fail_out // {precise, accumulator, coarse, period}
);
  localparam [15:0] SCM_LO = NOM_PER >> 1;
  localparam [15:0] SCM_HI = NOM_PER + (NOM_PER >> 1);
  localparam [31:0] CFM_EXP = CFM_WIN / {16'h0000, NOM_PER};
  localparam [31:0] CFM_TOL = (CFM_EXP * 32'd3) / 32'd100;
  localparam [31:0] PFM_EXP = PFM_WIN / {16'h0000, NOM_PER};
  // limits in tenths of a ppm; rejection wider than acceptance for hysteresis
  function [10:0] rsm_oor_lim;
    input [2:0] code;
    input rej;
    begin
      case (code)
        3'h0: rsm_oor_lim = rej ? 11'd120 : 11'd92;
        3'h1: rsm_oor_lim = rej ? 11'd520 : 11'd400;
        3'h2: rsm_oor_lim = rej ? 11'd1300 : 11'd1000;
        3'h3: rsm_oor_lim = rej ? 11'd830 : 11'd640;
        3'h4: rsm_oor_lim = rej ? 11'd180 : 11'd138;
        3'h5: rsm_oor_lim = rej ? 11'd320 : 11'd246;
        3'h6: rsm_oor_lim = rej ? 11'd475 : 11'd366;
        default: rsm_oor_lim = rej ? 11'd675 : 11'd520;
      endcase
    end
  endfunction
  reg ref_d_r, scm_r, cfm_r, gst_r, pfm_r;
  reg [15:0] per_r, dec_r;
  reg [31:0] cfm_t_r, cfm_n_r, pfm_t_r, pfm_n_r;
  reg [7:0] acc_r;
  wire edge_w = ref_in & ~ref_d_r;
  wire scm_evt_w = (edge_w & ((per_r < SCM_LO) | (per_r > SCM_HI)))
                 | (~edge_w & (per_r == SCM_HI + 16'h0001));
  wire cfm_end_w = (cfm_t_r == CFM_WIN - 32'd1);
  wire [31:0] cfm_now_w = cfm_n_r + {31'd0, edge_w};
  wire [31:0] cfm_dev_w = (cfm_now_w > CFM_EXP) ? cfm_now_w - CFM_EXP : CFM_EXP - cfm_now_w;
  wire cfm_evt_w = cfm_end_w & (cfm_dev_w > CFM_TOL);
  wire hit_w = (scm_evt_w & ~mask_scm_acc_in) | (cfm_evt_w & ~mask_cfm_acc_in);
  wire [15:0] dec_lim_w = `RSM_DECAY_BASE << {decay_sel_in, 1'b0};
  wire tick_w = (dec_r >= dec_lim_w);
  wire restart_w = scm_evt_w | cfm_evt_w;
  wire pfm_end_w = (pfm_t_r == PFM_WIN - 32'd1);
  wire [31:0] pfm_now_w = pfm_n_r + {31'd0, edge_w};
  wire [31:0] pfm_dev_w = (pfm_now_w > PFM_EXP) ? pfm_now_w - PFM_EXP : PFM_EXP - pfm_now_w;
  wire [63:0] dev_sc_w = {32'd0, pfm_dev_w} * 64'd10000000;
  wire [63:0] acc_th_w = {53'd0, rsm_oor_lim(oor_code_in, 1'b0)} * {32'd0, PFM_EXP};
  wire [63:0] rej_th_w = {53'd0, rsm_oor_lim(oor_code_in, 1'b1)} * {32'd0, PFM_EXP};
  // all four monitors; references start failed so they must qualify first
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ref_d_r <= 1'b0;
      per_r <= 16'h0000;
      scm_r <= 1'b1;
      cfm_t_r <= 32'h00000000;
      cfm_n_r <= 32'h00000000;
      cfm_r <= 1'b1;
      acc_r <= `RSM_GST_UPPER;
      dec_r <= 16'h0000;
      gst_r <= 1'b1;
      pfm_t_r <= 32'h00000000;
      pfm_n_r <= 32'h00000000;
      pfm_r <= 1'b1;
    end else begin
      ref_d_r <= ref_in;
      per_r <= edge_w ? 16'h0001 : ((per_r == 16'hFFFF) ? per_r : per_r + 16'h0001);
      if (scm_evt_w) begin
        scm_r <= 1'b1; // [R11]
      end else if (edge_w) begin
        scm_r <= 1'b0;
      end
      cfm_t_r <= cfm_end_w ? 32'h00000000 : cfm_t_r + 32'd1;
      cfm_n_r <= cfm_end_w ? 32'h00000000 : cfm_now_w;
      if (cfm_end_w) begin
        cfm_r <= cfm_evt_w; // [R12]
      end
      dec_r <= tick_w ? 16'h0000 : dec_r + 16'h0001;
      if (hit_w) begin
        acc_r <= (acc_r >= `RSM_GST_UPPER - `RSM_GST_STEP) ? `RSM_GST_UPPER
               : acc_r + `RSM_GST_STEP; // [R13] [R21]
      end else if (tick_w && acc_r != 8'h00) begin
        acc_r <= acc_r - 8'h01; // [R14]
      end
      if (acc_r >= `RSM_GST_UPPER) begin
        gst_r <= 1'b1; // [R13]
      end else if (acc_r <= `RSM_GST_LOWER) begin
        gst_r <= 1'b0; // [R14]
      end
      // any irregularity spoils the long count, so start it over
      if (restart_w || pfm_end_w) begin
        pfm_t_r <= 32'h00000000; // [R17]
        pfm_n_r <= 32'h00000000;
      end else begin
        pfm_t_r <= pfm_t_r + 32'd1;
        pfm_n_r <= pfm_now_w;
      end
      if (pfm_end_w && !restart_w) begin
        pfm_r <= pfm_r ? (dev_sc_w > acc_th_w) : (dev_sc_w > rej_th_w); // [R15] [R16]
      end
    end
  end
  assign fail_out = {pfm_r, gst_r, cfm_r, scm_r};
endmodule
`default_nettype wire

// [rsm_ref_select.v]
// The address-and-strobe port was left to the implementer.
`include "rsm_defines.vh"
`default_nettype none
// Summary of operation
// R1 - mode register picks automatic or manual reference selection
// R2 - automatic selection considers only currently valid references
// R3 - automatic selection with no valid reference goes to holdover by itself
// R4 - each reference has a priority; code 1111 excludes it from automatic choice
// R5 - revertive: always use best valid reference, switch when better one appears
// R6 - non-revertive: keep active while valid, then move to best valid one
// R7 - equal priorities resolve toward the lowest reference index
// R8 - per-reference revertive bits enable reverting to that reference
// R9 - manual mode uses the written index; invalid reference means holdover
// R10 - all inputs watched always; new references qualify before use
// R11 - period checker fails a period off nominal by more than half
// R12 - coarse checker fails a short window off by more than three percent
// R13 - accumulator integrates events, decays at chosen rate, fails at upper level
// R14 - accumulator counts down and requalifies at lower level
// R15 - precise checker over ten seconds against oscillator, out-of-range fails
// R16 - three-bit code selects acceptance and rejection ppm with hysteresis
// R17 - precise measurement restarts on any period or coarse irregularity
// R18 - four masked monitor failures ORed per reference; each shown in status
// R19 - change in failure status pulls active-low interrupt low unless masked
// R20 - per-reference bits mask each monitor from the combined failure
// R21 - separate bits keep period and coarse events out of the accumulator
// R22 - sync inputs checked for correct reference cycles per sync period
// R23 - frame pulse input follows the selected reference; only aligns frames
module rsm_ref_select #(
  parameter [15:0] NOM_PER = `RSM_NOM_PER,
  parameter [31:0] CFM_WIN = `RSM_CFM_WIN_CYC,
  parameter [31:0] PFM_WIN = `RSM_PFM_WIN_CYC,
  parameter [15:0] SYNC_RATIO = `RSM_SYNC_RATIO
) (
  input wire core_clk_in, // 200 MHz oscillator clock
  input wire rst_n_in, // synchronous reset, active low
  input wire [2:0] reference_input_in, // reference clocks, one per bit
  input wire [2:0] frame_pulse_input_in, // frame pulses, one per bit
  input wire [7:0] reg_addr_in, // register offset
  input wire [7:0] reg_wdata_in, // write data
  input wire reg_wr_in, // write strobe
  input wire reg_rd_in, // read strobe
  output wire [7:0] reg_rdata_out, // read data, cycle after strobe
  output wire irq_n_out, // interrupt, active low
  output wire [1:0] active_ref_out, // selected reference index
  output wire holdover_out, // no reference in use
  output wire [2:0] ref_valid_out, // per-reference qualified flag
  output wire sel_frame_pulse_out // frame pulse of the active reference
);
  // ----------------------------------------------------------------
  // selection states
  // ----------------------------------------------------------------
  localparam [1:0] ST_HOLD = 2'd0;
  localparam [1:0] ST_LOCK = 2'd1;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  reg [7:0] irq_mask_r;
  reg [7:0] mon_mask0_r;
  reg [7:0] mon_mask1_r;
  reg [7:0] oor0_r;
  reg [7:0] oor1_r;
  reg [7:0] acc_mask_r;
  reg [7:0] loop1_r;
  reg [7:0] mode_r;
  reg [7:0] man_sel_r;
  reg [7:0] rev_r;
  reg [7:0] pri0_r;
  reg [7:0] pri1_r;
  reg [7:0] decay_r;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;

  // register writes; read-only and unmapped offsets ignore writes
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_mask_r <= `RSM_RST_IRQ_MASK;
      mon_mask0_r <= `RSM_RST_MON_MASK;
      mon_mask1_r <= `RSM_RST_MON_MASK;
      oor0_r <= `RSM_RST_OOR;
      oor1_r <= `RSM_RST_OOR;
      acc_mask_r <= `RSM_RST_ACC_MASK;
      loop1_r <= `RSM_RST_LOOP_CTRL1;
      mode_r <= `RSM_RST_MODE;
      man_sel_r <= `RSM_RST_MAN_SEL;
      rev_r <= `RSM_RST_REV_CTRL;
      pri0_r <= `RSM_RST_PRI0;
      pri1_r <= `RSM_RST_PRI1;
      decay_r <= `RSM_RST_DECAY;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `RSM_OFF_IRQ_MASK) begin
        irq_mask_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_MON_MASK0) begin
        mon_mask0_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_MON_MASK1) begin
        mon_mask1_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_OOR0) begin
        oor0_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_OOR1) begin
        oor1_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_ACC_MASK) begin
        acc_mask_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_LOOP_CTRL1) begin
        loop1_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_MODE) begin
        mode_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_MAN_SEL) begin
        man_sel_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_REV_CTRL) begin
        rev_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_PRI0) begin
        pri0_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_PRI1) begin
        pri1_r <= reg_wdata_in;
      end else if (reg_addr_in == `RSM_OFF_DECAY) begin
        decay_r <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-reference monitors
  // ----------------------------------------------------------------
  // packed views: four bits per reference, reference 0 lowest
  wire [11:0] mon_fail_w;
  wire [11:0] mon_mask_w = {mon_mask1_r[3:0], mon_mask0_r};
  wire [11:0] oor_w = {1'b0, oor1_r[2:0], 1'b0, oor0_r[6:4], 1'b0, oor0_r[2:0]};
  wire [11:0] pri_w = {pri1_r[3:0], pri0_r};
  wire [2:0] sync_fail_w;
  wire [2:0] ref_fail_w;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ref
      // monitors run whether or not the reference is selected
      rsm_ref_monitor #(
        .NOM_PER(NOM_PER),
        .CFM_WIN(CFM_WIN),
        .PFM_WIN(PFM_WIN)
      ) u_mon (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .ref_in(reference_input_in[gi]), // [R10]
        .mask_scm_acc_in(acc_mask_r[gi]), // [R21]
        .mask_cfm_acc_in(acc_mask_r[gi + `RSM_ACC_CFM_LSB]), // [R21]
        .decay_sel_in(decay_r[1:0]),
        .oor_code_in(oor_w[gi * 4 +: 3]), // [R16]
        .fail_out(mon_fail_w[gi * 4 +: 4])
      );
      rsm_sync_ratio #(
        .RATIO(SYNC_RATIO)
      ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .ref_in(reference_input_in[gi]),
        .sync_in(frame_pulse_input_in[gi]),
        .fail_out(sync_fail_w[gi]) // [R22]
      );
      // a masked monitor cannot fail the reference
      assign ref_fail_w[gi] = |(mon_fail_w[gi * 4 +: 4] & ~mon_mask_w[gi * 4 +: 4]); // [R18] [R20]
    end
  endgenerate

  // ----------------------------------------------------------------
  // failure status and interrupt
  // ----------------------------------------------------------------
  reg [2:0] ref_fail_r;
  reg [2:0] pend_r;
  reg irq_n_r;
  wire irq_rd_w = reg_rd_in & (reg_addr_in == `RSM_OFF_IRQ_STATUS);
  wire [2:0] change_w = ref_fail_w ^ ref_fail_r;
  // a change in the same cycle as the clearing read stays pending
  wire [2:0] pend_nxt = (pend_r & ~{3{irq_rd_w}}) | (change_w & ~irq_mask_r[2:0]); // [R19]

  // status copy, pending changes and the interrupt pin
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ref_fail_r <= 3'b111;
      pend_r <= 3'b000;
      irq_n_r <= 1'b1;
    end else begin
      ref_fail_r <= ref_fail_w;
      pend_r <= pend_nxt;
      irq_n_r <= ~|pend_nxt; // [R19]
    end
  end

  // ----------------------------------------------------------------
  // reference selection
  // ----------------------------------------------------------------
  // best eligible reference; scanning downward with <= lets lower index win ties
  function [2:0] rsm_pick;
    input [2:0] elig;
    input [11:0] pri;
    integer i;
    reg [3:0] best;
    begin
      rsm_pick = 3'b000;
      best = `RSM_PRI_EXCLUDE;
      for (i = 2; i >= 0; i = i - 1) begin
        if (elig[i] && (pri[i * 4 +: 4] <= best)) begin
          best = pri[i * 4 +: 4];
          rsm_pick = {1'b1, i[1:0]}; // [R5] [R7]
        end
      end
    end
  endfunction

  // exclusion code 1111 keeps a reference out of automatic choice
  function rsm_allowed;
    input [3:0] pri;
    begin
      rsm_allowed = (pri != `RSM_PRI_EXCLUDE); // [R4]
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] act_r;
  reg [1:0] act_nxt;
  reg fp_r;
  wire [2:0] ref_valid_w = ~ref_fail_w; // [R2] [R10]
  wire [3:0] elig_w = {1'b0,
                       ref_valid_w[2] & rsm_allowed(pri_w[11:8]),
                       ref_valid_w[1] & rsm_allowed(pri_w[7:4]),
                       ref_valid_w[0] & rsm_allowed(pri_w[3:0])}; // [R2] [R4]
  wire [3:0] valid4_w = {1'b0, ref_valid_w};
  wire [2:0] pick_w = rsm_pick(elig_w[2:0], pri_w);
  wire [3:0] rev4_w = {1'b0, rev_r[2:0]};
  // reverting to a better reference is allowed globally or by that reference
  wire revert_w = loop1_r[`RSM_REVERT_BIT] | rev4_w[pick_w[1:0]]; // [R5] [R8]

  // next selection; an unknown mode code falls back to holdover
  always @* begin
    state_nxt = state_r;
    act_nxt = act_r;
    if (mode_r[2:0] == `RSM_MODE_MANUAL) begin // [R1]
      if (man_sel_r[1:0] != 2'd3 && valid4_w[man_sel_r[1:0]]) begin
        state_nxt = ST_LOCK; // [R9]
        act_nxt = man_sel_r[1:0];
      end else begin
        state_nxt = ST_HOLD; // [R9]
      end
    end else if (mode_r[2:0] == `RSM_MODE_AUTO) begin // [R1]
      case (state_r)
        ST_HOLD: begin
          if (pick_w[2]) begin
            state_nxt = ST_LOCK; // [R2]
            act_nxt = pick_w[1:0];
          end
        end
        ST_LOCK: begin
          if (!elig_w[act_r]) begin
            if (pick_w[2]) begin
              act_nxt = pick_w[1:0]; // [R6]
            end else begin
              state_nxt = ST_HOLD; // [R3]
            end
          end else if (pick_w[1:0] != act_r && revert_w) begin
            act_nxt = pick_w[1:0]; // [R5]
          end
        end
        default: begin
          state_nxt = ST_HOLD;
        end
      endcase
    end else begin
      state_nxt = ST_HOLD;
    end
  end

  // selection state and the frame pulse that follows the active reference
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_HOLD;
      act_r <= 2'd0;
      fp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      act_r <= act_nxt;
      // frame pulse only aligns outputs; it never enters the selection
      fp_r <= (state_nxt == ST_LOCK) & frame_pulse_input_in[act_nxt]; // [R23]
    end
  end

  // ----------------------------------------------------------------
  // register read-back
  // ----------------------------------------------------------------
  // status views, reference 0 in the lowest nibble or bit
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_addr_in == `RSM_OFF_IRQ_STATUS) begin
      rdata_nxt = {5'h00, ref_fail_r};
    end else if (reg_addr_in == `RSM_OFF_MON_STAT0) begin
      rdata_nxt = mon_fail_w[7:0]; // [R18]
    end else if (reg_addr_in == `RSM_OFF_MON_STAT1) begin
      rdata_nxt = {4'h0, mon_fail_w[11:8]}; // [R18]
    end else if (reg_addr_in == `RSM_OFF_IRQ_MASK) begin
      rdata_nxt = irq_mask_r;
    end else if (reg_addr_in == `RSM_OFF_MON_MASK0) begin
      rdata_nxt = mon_mask0_r;
    end else if (reg_addr_in == `RSM_OFF_MON_MASK1) begin
      rdata_nxt = mon_mask1_r;
    end else if (reg_addr_in == `RSM_OFF_SYNC_STAT0) begin
      rdata_nxt = {5'h00, sync_fail_w}; // [R22]
    end else if (reg_addr_in == `RSM_OFF_SYNC_STAT1) begin
      rdata_nxt = 8'h00;
    end else if (reg_addr_in == `RSM_OFF_OOR0) begin
      rdata_nxt = oor0_r;
    end else if (reg_addr_in == `RSM_OFF_OOR1) begin
      rdata_nxt = oor1_r;
    end else if (reg_addr_in == `RSM_OFF_ACC_MASK) begin
      rdata_nxt = acc_mask_r;
    end else if (reg_addr_in == `RSM_OFF_LOOP_CTRL1) begin
      rdata_nxt = loop1_r;
    end else if (reg_addr_in == `RSM_OFF_MODE) begin
      rdata_nxt = mode_r;
    end else if (reg_addr_in == `RSM_OFF_MAN_SEL) begin
      rdata_nxt = man_sel_r;
    end else if (reg_addr_in == `RSM_OFF_REV_CTRL) begin
      rdata_nxt = rev_r;
    end else if (reg_addr_in == `RSM_OFF_PRI0) begin
      rdata_nxt = pri0_r;
    end else if (reg_addr_in == `RSM_OFF_PRI1) begin
      rdata_nxt = pri1_r;
    end else if (reg_addr_in == `RSM_OFF_DECAY) begin
      rdata_nxt = decay_r;
    end else if (reg_addr_in == `RSM_OFF_SEL_STAT) begin
      rdata_nxt = {5'h00, (state_r == ST_HOLD), act_r};
    end
  end

  // data stand only in the cycle after the read strobe
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd_in ? rdata_nxt : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out = rdata_r;
  assign irq_n_out = irq_n_r;
  assign active_ref_out = act_r;
  assign holdover_out = (state_r == ST_HOLD); // [R3]
  assign ref_valid_out = ~ref_fail_r;
  assign sel_frame_pulse_out = fp_r;
endmodule
`default_nettype wire

// [rsm_ref_select_sva.sv]
`default_nettype none
// --
// port checks
// --
module rsm_ref_select_sva (
  input wire logic core_clk_in, // clock
  input wire logic rst_n_in, // reset, low
  input wire logic [7:0] reg_addr_in, // offset
  input wire logic [7:0] reg_wdata_in, // wdata
  input wire logic reg_wr_in, // write
  input wire logic reg_rd_in, // read
  input wire logic [7:0] reg_rdata_out, // rdata
  input wire logic irq_n_out, // irq, low
  input wire logic [1:0] active_ref_out, // active
  input wire logic holdover_out, // holdover
  input wire logic [2:0] ref_valid_out, // valid
  input wire logic sel_frame_pulse_out // pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // write then read back of the priority pair
  sequence pri_wr_rd;
    reg_wr_in && reg_addr_in == 8'h24 ##1 reg_rd_in && reg_addr_in == 8'h24;
  endsequence
  pri_back_a: assert property (pri_wr_rd |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("priority readback wrong");
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside slot");
  unmapped_rd_a: assert property (reg_rd_in && reg_addr_in == 8'h40 |=> !reg_rdata_out)
    else $error("unmapped read not zero");
  sel_status_a: assert property (reg_rd_in && reg_addr_in == 8'h31 |=>
    reg_rdata_out == {5'h00, $past(holdover_out), $past(active_ref_out)}) else $error("status");
  none_valid_a: assert property (ref_valid_out == 3'h0 |-> ##[0:2] holdover_out)
    else $error("no holdover without valid reference");
  act_valid_a: assert property (not ((!holdover_out && !ref_valid_out[active_ref_out])[*3]))
    else $error("active reference invalid");
  quiet_fp_a: assert property (holdover_out && $past(holdover_out) |-> !sel_frame_pulse_out)
    else $error("frame pulse in holdover");
  irq_release_a: assert property ($rose(irq_n_out) |-> $past(reg_rd_in && reg_addr_in == 8'h02))
    else $error("irq released without status read");
endmodule
bind rsm_ref_select rsm_ref_select_sva rsm_ref_select_sva_i (.core_clk_in, .rst_n_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_n_out,
  .active_ref_out, .holdover_out, .ref_valid_out, .sel_frame_pulse_out);
`default_nettype wire

// [rsm_src_model.sv]
`default_nettype none
// --
// reference and frame pulse sources
// --
module rsm_src_model (
  input wire logic clk_in, // oscillator
  input wire logic [2:0] run_in, // per-source enable
  output logic [2:0] ref_out, // clocks
  output logic [2:0] fp_out // frame pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] ph_r = 5'h00;
  // four-cycle clocks; a stopped source sits low, as a dead oscillator would
  always_ff @(posedge clk_in) begin
    ph_r <= ph_r + 5'h01;
    ref_out <= run_in & {3{ph_r[1]}};
    fp_out <= run_in & {3{ph_r == 5'h1F}}; // eight clock periods a frame
  end
endmodule
`default_nettype wire

// [rsm_sync_ratio.v]
`include "rsm_defines.vh"
`default_nettype none
module rsm_sync_ratio #(
  parameter [15:0] RATIO = `RSM_SYNC_RATIO
) (
  input wire core_clk_in, // system clock
  input wire rst_n_in, // synchronous reset, active low
  input wire ref_in, // reference clock sample
  input wire sync_in, // frame pulse sample
  output wire fail_out // ratio wrong or pulse missing
);
  reg ref_d_r;
  reg sync_d_r;
  reg [15:0] cnt_r;
  reg fail_r;
  wire ref_edge_w = ref_in & ~ref_d_r;
  wire sync_edge_w = sync_in & ~sync_d_r;
  // count reference edges between frame pulse rising edges
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ref_d_r <= 1'b0;
      sync_d_r <= 1'b0;
      cnt_r <= 16'h0000;
      fail_r <= 1'b1;
    end else begin
      ref_d_r <= ref_in;
      sync_d_r <= sync_in;
      if (sync_edge_w) begin
        fail_r <= (cnt_r != RATIO); // [R22]
        cnt_r <= {15'h0000, ref_edge_w};
      end else if (ref_edge_w) begin
        if (cnt_r != 16'hFFFF) begin
          cnt_r <= cnt_r + 16'h0001;
        end
        // too many cycles means the pulse went missing; flag it early
        if (cnt_r >= RATIO) begin
          fail_r <= 1'b1; // [R22]
        end
      end
    end
  end
  assign fail_out = fail_r;
endmodule
`default_nettype wire

// [tb.sv]
`default_nettype none
// --
// bench top
// --
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  logic [2:0] run = 3'h7;
  wire [7:0] rdata;
  wire [2:0] refs, fps, valid;
  wire [1:0] act;
  wire irq_n, hold, fp;
  int n_errors = 0, checks = 0, cyc = 0;
  // clock; ceiling well above the ~14k cycles the first qualification needs
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      test_done();
    end
  end
  rsm_src_model rsm_src_model_i (.clk_in(clk), .run_in(run), .ref_out(refs), .fp_out(fps));
  rsm_ref_select #(.NOM_PER(16'h4), .CFM_WIN(32'hC8), .PFM_WIN(32'h7D0), .SYNC_RATIO(16'h8))
    rsm_ref_select_i (.core_clk_in(clk), .rst_n_in(rst_n), .reference_input_in(refs),
    .frame_pulse_input_in(fps), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_n_out(irq_n), .active_ref_out(act),
    .holdover_out(hold), .ref_valid_out(valid), .sel_frame_pulse_out(fp));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bus tasks start right after an edge; a write leaves its strobe for the next task to drop
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic wait_v(input logic [2:0] v);
    wr <= 1'b0;
    for (int i = 0; i < 30000 && valid !== v; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    #1 chk({5'h00, valid}, {5'h00, v});
    @(posedge clk);
  endtask
  task automatic t_regs();
    rd_chk(8'h1F, 8'h01);
    rd_chk(8'h25, 8'h02);
    wr_reg(8'h24, 8'h21);
    rd_chk(8'h24, 8'h21);
    rd_chk(8'h40, 8'h00);
  endtask
  task automatic t_qual();
    wait_v(3'h7);
    rd_chk(8'h14, 8'h00);
    chk({7'h00, irq_n}, 8'h00);
    rd_chk(8'h02, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    rd_chk(8'h31, 8'h00);
  endtask
  task automatic t_switch();
    wr_reg(8'h09, 8'h01);
    run <= 3'h6;
    wait_v(3'h6);
    rd_chk(8'h31, 8'h01);
    @(posedge fps[1]) @(posedge clk) #1 chk({7'h00, fp}, 8'h01);
    @(posedge clk);
    chk({7'h00, irq_n}, 8'h01);
    run <= 3'h7;
    wait_v(3'h7);
    rd_chk(8'h31, 8'h01);
    wr_reg(8'h1E, 8'h01);
    wait_v(3'h7);
    rd_chk(8'h31, 8'h00);
  endtask
  task automatic t_man();
    wr_reg(8'h1F, 8'h00);
    wr_reg(8'h20, 8'h02);
    wait_v(3'h7);
    rd_chk(8'h31, 8'h02);
    chk({6'h00, act}, 8'h02);
    run <= 3'h3;
    wait_v(3'h3);
    rd_chk(8'h31, 8'h06);
    wr_reg(8'h0D, 8'h0F);
    wait_v(3'h7);
  endtask
  task automatic t_excl();
    wr_reg(8'h1F, 8'h01);
    wr_reg(8'h24, 8'hFF);
    wr_reg(8'h25, 8'h0F);
    wait_v(3'h7);
    chk({7'h00, hold}, 8'h01);
  endtask
  task automatic test_done();
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_qual();
    t_switch();
    t_man();
    t_excl();
    test_done();
  end
endmodule
`default_nettype wire
